// *** dco_cfg.svh ***
// Constants for the DDR2 channel organisation block.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef DCO_CFG_SVH
`define DCO_CFG_SVH
`define DCO_SEL_LSB 6
`define DCO_DCC_SEL_HI 10
`define DCO_DCC_SEL_LO 9
`define DCO_BND_LSB 25
`define DCO_AP_BIT 10
`define DCO_COL_TOP 9
`define DCO_MAX_RANK_DUAL 3'h2
`define DCO_MAX_RANK_SINGLE 3'h3
`define DCO_MIN_UNITS 9'h004
`define DCO_MAX_UNITS 9'h080
`define DCO_TECH_MAX 2'h2
`endif

// *** dco_pkg.sv ***
// Types shared by the DDR2 channel organisation block.
// Assumes dco_cfg.svh supplies the numeric constants.
package dco_pkg;
    typedef enum logic [1:0] {
        DCO_SINGLE = 2'b00,
        DCO_SYM = 2'b01,
        DCO_ASYM = 2'b10
    } dco_mode_t;
    typedef enum logic [1:0] {
        DCO_F400 = 2'b00,
        DCO_F533 = 2'b01,
        DCO_F667 = 2'b10
    } dco_freq_t;
    typedef struct packed {
        logic [1:0] tech;
        logic x16;
        logic page8k;
    } dco_rank_cfg_t;
    typedef struct packed {
        logic [31:6] line;
        logic [1:0] rank;
        logic [13:0] col;
        logic page8k;
    } dco_cmd_t;
endpackage : dco_pkg

// *** dco_chan_org.sv ***
// Channel organisation and address steering for a two channel DDR2 controller.
// Assumes a host that holds a cache-line request until acknowledged, and channel
// back ends that pulse a done input when the read data of an issued request returns.
//
// Summary of operation
// - Single, dual symmetric and dual asymmetric organisations, one module per channel.
// - Each channel is 64 bits wide at 400, 533 or 667 MHz.
// - Symmetric mode alternates channels every 1, 2, 4 or 8 64-byte cache lines.
// - Channel select address bit chosen by channel control bits 10:9.
// - A request to the idle channel issues while the other awaits data.
// - Symmetric with control bits 10:9 zero: consecutive lines land on opposite channels and can run together.
// - Asymmetric fills channel A to its top, then channel B upward.
// - Asymmetric works with any rank or whole channel empty.
// - 256 Mb, 512 Mb and 1 Gb devices, x8 and x16, supported.
// - Page size 4K or 8K chosen per rank in every mode.
// - Dual channel allows one or two ranks per channel, four total.
// - Single channel allows one, two or three ranks.
// - Memory frequency is the lowest of the installed modules on channel A and, in dual modes, channel B.
// - Single channel mode uses channel A only.
// - Decoded capacity spans 128 MB to 4 GB.
// - Reduced variant: one soldered 400 MHz channel, x16 devices only.
// - Column address bit 10 always carries auto-precharge.
`timescale 1ns/10ps
`include "dco_cfg.svh"

module dco_chan_org
    import dco_pkg::*;
#(
    parameter int RANKS = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [1:0] cfg_mode,
    input wire logic reduced_variant,
    input wire logic [10:0] dram_channel_control,
    input wire logic [7:0] rank_upper_boundary_a [RANKS],
    input wire logic [7:0] rank_upper_boundary_b [RANKS],
    input wire dco_rank_cfg_t rank_cfg_a [RANKS],
    input wire dco_rank_cfg_t rank_cfg_b [RANKS],
    input wire logic slot_pop_a,
    input wire logic slot_pop_b,
    input wire logic [1:0] spd_freq_a,
    input wire logic [1:0] spd_freq_b,
    input wire logic req_valid,
    input wire logic [31:6] req_addr,
    input wire logic req_ap,
    input wire logic cha_done,
    input wire logic chb_done,
    output logic req_ack,
    output logic addr_err,
    output logic cha_cmd_valid,
    output dco_cmd_t cha_cmd,
    output logic chb_cmd_valid,
    output dco_cmd_t chb_cmd,
    output logic [1:0] mem_freq,
    output logic cfg_err
);

    // ************************************************
    // Address decode
    // ************************************************
    dco_mode_t mode;
    logic [1:0] sel;
    logic [7:0] top_a;
    logic [7:0] top_b;
    logic sym_ch;
    logic in_a;
    logic tgt_ch;
    logic [31:6] sym_local;
    logic [31:6] local_addr;
    logic [31:6] rank_off;
    logic [1:0] hit_rank;
    logic hit;
    logic page8k;
    logic [13:0] col;
    logic go;
    logic issue;
    logic req_ack_q;
    logic addr_err_q;
    logic cha_cmd_valid_q;
    logic chb_cmd_valid_q;
    dco_cmd_t cha_cmd_q;
    dco_cmd_t chb_cmd_q;
    dco_cmd_t cmd_d;
    logic busy_a_q;
    logic busy_b_q;
    logic [1:0] mem_freq_q;
    logic [1:0] mem_freq_d;
    logic cfg_err_q;
    logic cfg_err_d;

    assign mode = dco_mode_t'(cfg_mode);
    assign sel = dram_channel_control[`DCO_DCC_SEL_HI:`DCO_DCC_SEL_LO];
    assign top_a = rank_upper_boundary_a[RANKS-1];
    assign top_b = rank_upper_boundary_b[RANKS-1];
    assign sym_ch = req_addr[`DCO_SEL_LSB + int'(sel)];

    // Drops the channel select bit to form the address inside one channel
    always_comb begin
        sym_local = '0;
        for (int i = 6; i < 31; i++) begin
            if (i < `DCO_SEL_LSB + int'(sel)) begin
                sym_local[i] = req_addr[i];
            end else begin
                sym_local[i] = req_addr[i+1];
            end
        end
    end

    assign in_a = {1'b0, req_addr[31:`DCO_BND_LSB]} < top_a;

    always_comb begin
        unique case (mode)
            DCO_SYM: begin
                tgt_ch = sym_ch;
                local_addr = sym_local;
            end
            DCO_ASYM: begin
                tgt_ch = !in_a;
                local_addr = in_a ? req_addr : req_addr - {top_a[6:0], 19'h00000};
            end
            default: begin
                tgt_ch = 1'b0;
                local_addr = req_addr;
            end
        endcase
    end

    // First rank whose cumulative boundary lies above the address
    always_comb begin
        hit = 1'b0;
        hit_rank = '0;
        rank_off = local_addr;
        page8k = 1'b0;
        for (int r = RANKS - 1; r >= 0; r--) begin
            if (tgt_ch == 1'b0 && {1'b0, local_addr[31:`DCO_BND_LSB]} < rank_upper_boundary_a[r]) begin
                hit = 1'b1;
                hit_rank = 2'(r);
                page8k = rank_cfg_a[r].page8k;
                rank_off = local_addr - (r == 0 ? 26'h0 : {rank_upper_boundary_a[r > 0 ? r - 1 : 0][6:0], 19'h00000});
            end
            if (tgt_ch == 1'b1 && {1'b0, local_addr[31:`DCO_BND_LSB]} < rank_upper_boundary_b[r]) begin
                hit = 1'b1;
                hit_rank = 2'(r);
                page8k = rank_cfg_b[r].page8k;
                rank_off = local_addr - (r == 0 ? 26'h0 : {rank_upper_boundary_b[r > 0 ? r - 1 : 0][6:0], 19'h00000});
            end
        end
    end

    always_comb begin
        col = {4'h0, rank_off[12:6], 3'h0};
        col[`DCO_AP_BIT] = req_ap;
        if (!page8k) begin
            col[`DCO_COL_TOP] = 1'b0;
        end
    end

    assign cmd_d = '{line: rank_off, rank: hit_rank, col: col, page8k: page8k};
    assign go = req_valid && !req_ack_q && !(hit && (tgt_ch ? busy_b_q : busy_a_q));
    assign issue = go && hit && !cfg_err_q;

    // ************************************************
    // Request issue and channel occupancy
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            req_ack_q <= 1'b0;
            addr_err_q <= 1'b0;
        end else begin
            req_ack_q <= go;
            addr_err_q <= go && !issue;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cha_cmd_valid_q <= 1'b0;
            chb_cmd_valid_q <= 1'b0;
            cha_cmd_q <= '0;
            chb_cmd_q <= '0;
        end else begin
            cha_cmd_valid_q <= issue && !tgt_ch;
            chb_cmd_valid_q <= issue && tgt_ch;
            if (issue && !tgt_ch) begin
                cha_cmd_q <= cmd_d;
            end
            if (issue && tgt_ch) begin
                chb_cmd_q <= cmd_d;
            end
        end
    end

    // A new issue wins over a done arriving in the same cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            busy_a_q <= 1'b0;
            busy_b_q <= 1'b0;
        end else begin
            busy_a_q <= (issue && !tgt_ch) || (busy_a_q && !cha_done);
            busy_b_q <= (issue && tgt_ch) || (busy_b_q && !chb_done);
        end
    end

    // ************************************************
    // Memory frequency
    // ************************************************
    always_comb begin
        mem_freq_d = DCO_F667;
        if (slot_pop_a && spd_freq_a < mem_freq_d) begin
            mem_freq_d = spd_freq_a;
        end
        if (mode != DCO_SINGLE && slot_pop_b && spd_freq_b < mem_freq_d) begin
            mem_freq_d = spd_freq_b;
        end
        if (reduced_variant || !(slot_pop_a || slot_pop_b)) begin
            mem_freq_d = DCO_F400;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mem_freq_q <= DCO_F400;
        end else begin
            mem_freq_q <= mem_freq_d;
        end
    end

    // ************************************************
    // Configuration checking
    // ************************************************
    always_comb begin
        logic [2:0] cnt_a;
        logic [2:0] cnt_b;
        logic [8:0] total;
        logic x8_a;
        logic x16_a;
        logic x8_b;
        logic x16_b;
        cnt_a = '0;
        cnt_b = '0;
        x8_a = 1'b0;
        x16_a = 1'b0;
        x8_b = 1'b0;
        x16_b = 1'b0;
        total = (mode == DCO_SINGLE) ? {1'b0, top_a} : {1'b0, top_a} + {1'b0, top_b};
        cfg_err_d = 1'b0;
        for (int r = 0; r < RANKS; r++) begin
            if (rank_upper_boundary_a[r] > (r == 0 ? 8'h00 : rank_upper_boundary_a[r > 0 ? r - 1 : 0])) begin
                cnt_a = cnt_a + 3'h1;
                x8_a = x8_a | !rank_cfg_a[r].x16;
                x16_a = x16_a | rank_cfg_a[r].x16;
                cfg_err_d = cfg_err_d | (rank_cfg_a[r].tech > `DCO_TECH_MAX);
            end
            if (rank_upper_boundary_b[r] > (r == 0 ? 8'h00 : rank_upper_boundary_b[r > 0 ? r - 1 : 0])) begin
                cnt_b = cnt_b + 3'h1;
                x8_b = x8_b | !rank_cfg_b[r].x16;
                x16_b = x16_b | rank_cfg_b[r].x16;
                cfg_err_d = cfg_err_d | (rank_cfg_b[r].tech > `DCO_TECH_MAX);
            end
        end
        if (cfg_mode == 2'b11) begin
            cfg_err_d = 1'b1;
        end
        if (mode == DCO_SINGLE && cnt_a > `DCO_MAX_RANK_SINGLE) begin
            cfg_err_d = 1'b1;
        end
        if (mode != DCO_SINGLE && (cnt_a > `DCO_MAX_RANK_DUAL || cnt_b > `DCO_MAX_RANK_DUAL)) begin
            cfg_err_d = 1'b1;
        end
        if (total < `DCO_MIN_UNITS || total > `DCO_MAX_UNITS) begin
            cfg_err_d = 1'b1;
        end
        if (mode == DCO_SYM && (top_a != top_b || !slot_pop_a || !slot_pop_b)) begin
            cfg_err_d = 1'b1;
        end
        if ((x8_a && x16_a) || (x8_b && x16_b)) begin
            cfg_err_d = 1'b1;
        end
        if (reduced_variant && (mode != DCO_SINGLE || x8_a)) begin
            cfg_err_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_err_q <= 1'b0;
        end else begin
            cfg_err_q <= cfg_err_d;
        end
    end
    assign req_ack = req_ack_q;
    assign addr_err = addr_err_q;
    assign cha_cmd_valid = cha_cmd_valid_q;
    assign chb_cmd_valid = chb_cmd_valid_q;
    assign cha_cmd = cha_cmd_q;
    assign chb_cmd = chb_cmd_q;
    assign mem_freq = mem_freq_q;
    assign cfg_err = cfg_err_q;
    // ************************************************
    // Assertions
    // ************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_single_no_b: assert property (chb_cmd_valid_q |-> $past(mode) != DCO_SINGLE)
        else $error("Channel B used in single channel mode");
    a_sym_chan_pick: assert property (
        $past(issue) && $past(mode) == DCO_SYM |-> chb_cmd_valid_q == $past(sym_ch))
        else $error("Symmetric channel does not follow the select bit");
    a_sel_bit_use: assert property (
        $past(issue) && $past(mode) == DCO_SYM && $past(sel) == 2'h0
        |-> chb_cmd_valid_q == $past(req_addr[6]))
        else $error("Select field zero does not steer on address bit 6");
    a_busy_blocks: assert property (busy_a_q && !cha_done |=> !cha_cmd_valid_q)
        else $error("Channel A issued while its read is outstanding");
    a_asym_linear: assert property (
        cha_cmd_valid_q && $past(mode) == DCO_ASYM |-> $past(in_a))
        else $error("Asymmetric address above channel A top sent to A");
    a_ap_bit: assert property (cha_cmd_valid_q |-> cha_cmd_q.col[10] == $past(req_ap))
        else $error("Auto precharge not on column bit 10");
    a_page_4k: assert property (cha_cmd_valid_q && !cha_cmd_q.page8k |-> cha_cmd_q.col[9] == 1'b0)
        else $error("4K page used column bit 9");
    a_freq_min: assert property (
        $past(slot_pop_a) && !$past(reduced_variant) |-> mem_freq_q <= $past(spd_freq_a))
        else $error("Memory frequency above module A capability");
    a_reduced_400: assert property ($past(reduced_variant) |-> mem_freq_q == DCO_F400)
        else $error("Reduced variant not at 400 MHz");
    a_ack_once: assert property (req_ack_q |=> !req_ack_q ##1 1'b1)
        else $error("Acknowledge longer than one cycle");
    a_err_no_cmd: assert property (addr_err_q |-> !cha_cmd_valid_q && !chb_cmd_valid_q)
        else $error("Command issued for an unmapped address");
    c_both_busy: cover property (busy_a_q && busy_b_q);
    c_asym_b: cover property (chb_cmd_valid_q && $past(mode) == DCO_ASYM);
    c_addr_err: cover property (addr_err_q);
endmodule : dco_chan_org

// *** dco_chan_model.sv ***
// Behavioural channel back end: pulses done a set number of cycles after a command.
// Assumes dly is at least 1 whenever a command arrives.
`timescale 1ns/10ps
module dco_chan_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] dly,
    output logic done
);
    int cnt_q;
    always_ff @(posedge mclk) begin
        done <= 1'b0;
        if (!nrst) begin
            cnt_q <= 0;
        end else if (cmd_valid) begin
            cnt_q <= int'(dly);
        end else if (cnt_q == 1) begin
            done <= 1'b1;
            cnt_q <= 0;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule : dco_chan_model

// *** dco_chan_org_tb.sv ***
// Self-checking bench for dco_chan_org against a reference steering model.
// Assumes dco_pkg, dco_chan_org and dco_chan_model are compiled first.
`timescale 1ns/10ps
module dco_chan_org_tb;
    import dco_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] cfg_mode = 2'h0;
    logic reduced_variant = 1'b0;
    logic [10:0] dram_channel_control = 11'h000;
    logic [7:0] bnd_a [4];
    logic [7:0] bnd_b [4];
    dco_rank_cfg_t rcfg_a [4];
    dco_rank_cfg_t rcfg_b [4];
    logic slot_pop_a = 1'b1;
    logic slot_pop_b = 1'b1;
    logic [1:0] spd_a = 2'h0;
    logic [1:0] spd_b = 2'h0;
    logic req_valid = 1'b0;
    logic [31:6] req_addr = 26'h0;
    logic req_ap = 1'b0;
    logic cha_done, chb_done, req_ack, addr_err, cha_cmd_valid, chb_cmd_valid, cfg_err;
    dco_cmd_t cha_cmd, chb_cmd;
    logic [1:0] mem_freq;
    logic [7:0] dly = 8'h01;
    integer seed = 32;
    int num_errors = 0;
    int n_checks = 0;
    int w;
    initial forever #5 mclk = ~mclk;
    dco_chan_org dut (.mclk(mclk), .nrst(nrst), .cfg_mode(cfg_mode), .reduced_variant(reduced_variant),
        .dram_channel_control(dram_channel_control), .rank_upper_boundary_a(bnd_a),
        .rank_upper_boundary_b(bnd_b), .rank_cfg_a(rcfg_a), .rank_cfg_b(rcfg_b), .slot_pop_a(slot_pop_a),
        .slot_pop_b(slot_pop_b), .spd_freq_a(spd_a), .spd_freq_b(spd_b), .req_valid(req_valid),
        .req_addr(req_addr), .req_ap(req_ap), .cha_done(cha_done), .chb_done(chb_done), .req_ack(req_ack),
        .addr_err(addr_err), .cha_cmd_valid(cha_cmd_valid), .cha_cmd(cha_cmd), .chb_cmd_valid(chb_cmd_valid),
        .chb_cmd(chb_cmd), .mem_freq(mem_freq), .cfg_err(cfg_err));
    dco_chan_model m_a (.mclk(mclk), .nrst(nrst), .cmd_valid(cha_cmd_valid), .dly(dly), .done(cha_done));
    dco_chan_model m_b (.mclk(mclk), .nrst(nrst), .cmd_valid(chb_cmd_valid), .dly(dly), .done(chb_done));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic setcfg(input logic [1:0] m, input int k, input logic [31:0] ba, input logic [31:0] bb,
                          input logic pa, input logic pb, input logic red);
        logic xa, xb;
        int ef;
        xa = red | 1'($random(seed));
        xb = 1'($random(seed));
        @(posedge mclk);
        cfg_mode <= m;
        dram_channel_control <= {k[1:0], 9'h000};
        reduced_variant <= red;
        slot_pop_a <= pa;
        slot_pop_b <= pb;
        spd_a <= 2'($unsigned($random(seed)) % 3);
        spd_b <= 2'($unsigned($random(seed)) % 3);
        for (int i = 0; i < 4; i++) begin
            bnd_a[i] <= ba[8*i+:8];
            bnd_b[i] <= bb[8*i+:8];
            rcfg_a[i] <= '{2'($unsigned($random(seed)) % 3), xa, 1'($random(seed))};
            rcfg_b[i] <= '{2'($unsigned($random(seed)) % 3), xb, 1'($random(seed))};
        end
        repeat (3) @(posedge mclk);
        #1;
        ef = 3;
        if (pa) ef = spd_a;
        if (pb && m != 2'h0 && spd_b < ef) ef = spd_b;
        if (red || ef == 3) ef = 0;
        chk("mem_freq", mem_freq, ef);
        chk("cfg_err", cfg_err, m == 2'h3);
    endtask : setcfg
    task automatic req(input logic [25:0] l, output int w);
        longint lo, off, top;
        int ch, rk, k;
        logic ap, e, p8;
        dco_cmd_t cm;
        ap = 1'($random(seed));
        k = int'(dram_channel_control[10:9]);
        ch = 0;
        lo = l;
        if (cfg_mode == 2'h1) begin
            ch = int'(l[k]);
            lo = ((l >> (k + 1)) << k) | (l & ((64'h1 << k) - 1));
        end else if (cfg_mode == 2'h2 && l >= (longint'(bnd_a[3]) << 19)) begin
            ch = 1;
            lo = l - (longint'(bnd_a[3]) << 19);
        end
        rk = 4;
        for (int r = 3; r >= 0; r--) begin
            top = longint'(ch ? bnd_b[r] : bnd_a[r]) << 19;
            if (lo < top) rk = r;
        end
        off = (rk > 0 && rk < 4) ? lo - (longint'(ch ? bnd_b[rk-1] : bnd_a[rk-1]) << 19) : lo;
        e = rk == 4 || cfg_mode == 2'h3;
        p8 = rk < 4 ? (ch ? rcfg_b[rk[1:0]].page8k : rcfg_a[rk[1:0]].page8k) : 1'b0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_addr <= l;
        req_ap <= ap;
        w = 0;
        do begin
            @(posedge mclk);
            #1;
            w++;
        end while (req_ack !== 1'b1 && w < 200);
        chk("ack", req_ack, 1'b1);
        chk("addr_err", addr_err, e);
        chk("cha_valid", cha_cmd_valid, !e && ch == 0);
        chk("chb_valid", chb_cmd_valid, !e && ch == 1);
        if (!e) begin
            cm = ch ? chb_cmd : cha_cmd;
            chk("line", cm.line, off);
            chk("rank", cm.rank, rk);
            chk("page8k", cm.page8k, p8);
            chk("col", cm.col, (longint'(ap) << 10) | ((p8 ? off & 'h7f : off & 'h3f) << 3));
        end
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask : req
    task automatic run(input logic [1:0] m, input int k, input logic [31:0] ba, input logic [31:0] bb,
                       input logic pa, input logic pb, input logic red);
        int w;
        longint cap;
        setcfg(m, k, ba, bb, pa, pb, red);
        cap = (longint'(ba[31:24]) + (m[0] == m[1] ? 0 : longint'(bb[31:24])) + 1) << 19;
        repeat (30) begin
            dly <= 8'(1 + $unsigned($random(seed)) % 8);
            req(26'($unsigned($random(seed)) % cap), w);
        end
        repeat (40) @(posedge mclk);
    endtask : run
    // Breaks one rule of a legal symmetric set-up and expects the configuration error
    task automatic bad(input int c);
        setcfg(2'h1, 0, 32'h20202010, 32'h20202020, 1'b1, 1'b1, 1'b0);
        @(posedge mclk);
        case (c)
            0: bnd_b[3] <= 8'h18;
            1: rcfg_b[0].tech <= 2'h3;
            2: rcfg_a[1].x16 <= !rcfg_a[0].x16;
            3: bnd_a[1] <= 8'h18;
            4: for (int i = 1; i < 4; i++) begin
                bnd_a[i] <= 8'h48;
                bnd_b[i] <= 8'h48;
            end
            5: for (int i = 0; i < 4; i++) begin
                bnd_a[i] <= 8'h01;
                bnd_b[i] <= 8'h01;
            end
            6: reduced_variant <= 1'b1;
            default: begin
                cfg_mode <= 2'h0;
                for (int i = 0; i < 4; i++) bnd_a[i] <= 8'(4 * i + 4);
            end
        endcase
        repeat (2) @(posedge mclk);
        #1;
        chk("cfg_bad", cfg_err, 1'b1);
    endtask : bad
    // ****************
    // Main sequence
    // ****************
    initial begin
        for (int i = 0; i < 4; i++) begin
            bnd_a[i] = 8'h00;
            bnd_b[i] = 8'h00;
            rcfg_a[i] = '0;
            rcfg_b[i] = '0;
        end
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        run(2'h0, 0, 32'h08080804, 32'h0, 1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) run(2'h1, k, 32'h20202010, 32'h20202020, 1'b1, 1'b1, 1'b0);
        run(2'h2, 0, 32'h30303010, 32'h18181808, 1'b1, 1'b1, 1'b0);
        run(2'h2, 0, 32'h0, 32'h10101010, 1'b0, 1'b1, 1'b0);
        run(2'h3, 0, 32'h08080804, 32'h0, 1'b1, 1'b0, 1'b0);
        setcfg(2'h1, 0, 32'h20202010, 32'h20202020, 1'b1, 1'b1, 1'b0);
        dly <= 8'h1e;
        req(26'h100, w);
        req(26'h101, w);
        chk("wait", w, 1);
        req(26'h102, w);
        chk("busy", w > 20, 1'b1);
        for (int c = 0; c < 8; c++) bad(c);
        conclude();
    end
    initial begin
        #300000;
        num_errors++;
        conclude();
    end
endmodule : dco_chan_org_tb
